//--- rtl/aic_filter.sv
/*
  First-order smoothing step for one sample.
  Assumes the caller holds the previous output per channel.
*/
`timescale 1ns/100ps
module aic_filter
  import aic_pkg::*;
(
  input  wire logic [2:0]         filtSel,
  input  wire logic               bypass,
  input  wire logic signed [15:0] prev,
  input  wire logic signed [15:0] sample,
  output logic signed [15:0]      result
);

  logic [12:0]        alpha;
  logic signed [31:0] acc;

  always_comb
  begin
    alpha = alpha_q(filtSel);
    acc = 32'(prev) * $signed({19'h0, alpha})
        + 32'(sample) * $signed({19'h0, FILT_ONE - alpha})
        + FILT_HALF;
    if (bypass || filtSel == 3'h0)
      result = sample;
    else
      result = 16'(acc >>> FILT_SHIFT);
  end

endmodule

//--- rtl/aic_pkg.sv
/*
  Constants, types and shared arithmetic for the analog input
  conditioning block. Assumes 8 channels, 16-bit signed samples and a
  7-bit register address space on a plain strobe port.
*/
package aic_pkg;

  localparam int NUM_CH = 8;
  localparam int CH_W   = 3;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;

  // Per-channel register slots, channel base is channel * 8
  localparam logic [2:0] SLOT_CFG    = 3'h0;
  localparam logic [2:0] SLOT_LOW    = 3'h1;
  localparam logic [2:0] SLOT_HIGH   = 3'h2;
  localparam logic [2:0] SLOT_ALIGN  = 3'h3;
  localparam logic [2:0] SLOT_VALUE  = 3'h4;
  localparam logic [2:0] SLOT_STATUS = 3'h5;
  // Module-wide registers
  localparam logic [6:0] ADDR_CTRL   = 7'h40;
  localparam logic [6:0] ADDR_CMD    = 7'h41;
  localparam logic [6:0] ADDR_CAL10  = 7'h42;
  localparam logic [6:0] ADDR_CAL5   = 7'h43;
  localparam int GLOBAL_BIT          = 6;

  // Field positions
  localparam int CFG_FILT_LSB   = 0;
  localparam int CFG_RANGE_LSB  = 3;
  localparam int CFG_USER_BIT   = 6;
  localparam int CTRL_FAST_BIT  = 0;
  localparam int CTRL_RECAL_BIT = 1;
  localparam int CMD_REF10_BIT  = 0;
  localparam int CMD_REF5_BIT   = 1;
  localparam int CMD_SAVE_BIT   = 2;
  localparam int CMD_FACT_BIT   = 3;
  localparam int STAT_ALIGN_BIT = 0;
  localparam int STAT_INVAL_BIT = 2;

  // Values after reset
  localparam logic [15:0]        CFG_RST     = 16'h0000;
  localparam logic signed [15:0] LOW_RST     = 16'sh0000;
  localparam logic signed [15:0] HIGH_RST    = 16'sh2710;
  localparam logic signed [15:0] CAL_FACTORY = 16'sh0000;

  // Sample and filter arithmetic
  localparam logic signed [15:0] RAW_FULL   = 16'sh4000;
  localparam int                 RAW_SHIFT  = 14;
  localparam logic signed [39:0] STD_FULL   = 40'sh0000002710;
  localparam logic signed [39:0] HALF_UNI   = 40'sh0000002000;
  localparam logic signed [39:0] HALF_BIP   = 40'sh0000004000;
  localparam int                 FILT_SHIFT = 12;
  localparam logic [12:0]        FILT_ONE   = 13'h1000;
  localparam logic signed [31:0] FILT_HALF  = 32'sh00000800;

  typedef enum logic [2:0] {
    RNG_BIP10 = 3'h0, RNG_UNI10 = 3'h1, RNG_UNI5 = 3'h2,
    RNG_1TO5 = 3'h3, RNG_20MA = 3'h4, RNG_4TO20 = 3'h5
  } aic_range_t;

  typedef enum logic [1:0] {
    MODE_RUN = 2'b00, MODE_RECAL = 2'b01, MODE_EXIT = 2'b11
  } aic_mode_t;

  typedef struct packed {
    logic                     wr;
    logic                     rd;
    logic [ADDR_W-1:0]        addr;
    logic [DATA_W-1:0]        wdata;
  } aic_regreq_t;

  typedef struct packed {
    logic                     valid;
    logic [CH_W-1:0]          chan;
    logic signed [DATA_W-1:0] raw;
  } aic_sample_t;

  typedef struct packed {
    logic                     valid;
    logic [CH_W-1:0]          chan;
    logic                     invalid;
    logic signed [DATA_W-1:0] value;
  } aic_result_t;

  // Smoothing coefficient in Q12
  function automatic logic [12:0] alpha_q(input logic [2:0] sel);
    case (sel)
      3'h1:    alpha_q = 13'h0C00;
      3'h2:    alpha_q = 13'h0E00;
      3'h3:    alpha_q = 13'h0EFE;
      3'h4:    alpha_q = 13'h0F81;
      3'h5:    alpha_q = 13'h0FBE;
      3'h6:    alpha_q = 13'h0FDF;
      default: alpha_q = 13'h0000;
    endcase
  endfunction

  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sh0000007FFF)
      sat16 = 16'sh7FFF;
    else if (v < -40'sh0000008000)
      sat16 = -16'sh8000;
    else
      sat16 = v[15:0];
  endfunction

  // Standard or user scaling with rounding
  function automatic logic signed [15:0] scale_val(
    input logic signed [15:0] x,
    input logic               bip,
    input logic               usr,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    logic signed [39:0] span;
    logic signed [39:0] p;
    span = 40'(hi) - 40'(lo);
    if (!usr)
      p = (40'(x) * STD_FULL + HALF_UNI) >>> RAW_SHIFT;
    else if (bip)
      p = 40'(lo) + (((40'(x) + HALF_BIP) * span + HALF_BIP)
          >>> (RAW_SHIFT + 1));
    else
      p = 40'(lo) + ((40'(x) * span + HALF_UNI) >>> RAW_SHIFT);
    scale_val = sat16(p);
  endfunction

endpackage

//--- rtl/aic_top.sv
/*
  Per-channel conditioning of converter samples: calibration offset,
  smoothing, standard or user scaling, alignment, recalibration.
  Assumes samples arrive one per cycle at most, synchronous to clock,
  as signed codes with range maximum at RAW_FULL.
*/
// Design decisions made here: the address map and the plain strobed port.
// Notes on behaviour
// - Each channel takes a filter setting from zero to six.
// - Settings map to coefficients 0 to 0.992; zero passes raw.
// - Filter setting may change at any time, used at once.
// - Fast cycle bypasses the filter completely.
// - Standard unipolar scales range to 0 through 10000.
// - Standard bipolar ten volt scales to minus and plus 10000.
// - User format maps range ends to programmed lower and upper.
// - Aligned channel adds its stored offset to each result.
// - Offset word is writable by software at any time.
// - Alignment does not change any channel operating mode.
// - Status bit zero shows that the channel holds an alignment.
// - Recalibration on channel 0 serves all channels.
// - Recalibration flags all invalid, stops filter and alignment.
// - Recalibration samples only channel 0, others hold values.
// - Ten volt reference fixes ten volt ranges, five the rest.
// - After ten volt fix channel 0 reads close to 10000.
// - Coefficients apply at once, are kept on save, else old ones return.
// - Factory restore drops user coefficients at once.
`timescale 1ns/100ps
module aic_top
  import aic_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                arst_n,
  input  wire logic                clockEn,
  input  wire aic_pkg::aic_regreq_t regReq,
  output logic [15:0]              regRdata,
  input  wire aic_pkg::aic_sample_t sampleIn,
  output aic_pkg::aic_result_t     resultOut
);

  logic [1:0]               rstSync;
  logic                     rstN;

  logic [15:0]              cfg         [NUM_CH];
  logic signed [15:0]       userLow     [NUM_CH];
  logic signed [15:0]       userHigh    [NUM_CH];
  logic signed [15:0]       alignment_offset_word [NUM_CH];
  logic signed [15:0]       filtState   [NUM_CH];
  logic signed [15:0]       chanValue   [NUM_CH];
  logic [15:0]              next_cfg    [NUM_CH];
  logic signed [15:0]       next_userLow  [NUM_CH];
  logic signed [15:0]       next_userHigh [NUM_CH];
  logic signed [15:0]       next_alignment_offset_word [NUM_CH];
  logic signed [15:0]       next_filtState [NUM_CH];
  logic signed [15:0]       next_chanValue [NUM_CH];

  logic                     fastCycle;
  logic                     next_fastCycle;
  aic_mode_t                mode;
  aic_mode_t                next_mode;
  logic signed [15:0]       calStored10;
  logic signed [15:0]       calStored5;
  logic signed [15:0]       calPend10;
  logic signed [15:0]       calPend5;
  logic signed [15:0]       next_calStored10;
  logic signed [15:0]       next_calStored5;
  logic signed [15:0]       next_calPend10;
  logic signed [15:0]       next_calPend5;
  logic signed [15:0]       ch0Raw;
  logic signed [15:0]       next_ch0Raw;

  aic_result_t              next_resultOut;
  logic [15:0]              next_regRdata;

  logic                     recalOn;
  logic                     accept;
  logic [CH_W-1:0]          ch;
  logic [15:0]              chCfg;
  logic                     group10;
  logic                     bipolar;
  logic signed [15:0]       calRaw;
  logic signed [15:0]       filtered;
  logic signed [15:0]       scaled;
  logic signed [15:0]       finalValue;
  logic                     cmdWrite;
  logic [CH_W-1:0]          regCh;
  logic [2:0]               regSlot;

  // Range field of a channel setting word
  function automatic logic [2:0] range_of(input logic [15:0] word);
    range_of = word[CFG_RANGE_LSB +: 3];
  endfunction

  // Reset release through two flops
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstN = rstSync[1];

  // Sample path decode
  always_comb
  begin
    recalOn = (mode != MODE_RUN);
    ch = sampleIn.chan;
    chCfg = cfg[ch];
    // Calibration group follows the range
    group10 = (range_of(chCfg) == RNG_BIP10)
           || (range_of(chCfg) == RNG_UNI10);
    bipolar = (range_of(chCfg) == RNG_BIP10);
    // Only channel 0 is read while recalibrating
    accept = sampleIn.valid && (!recalOn || ch == '0);
    // Pending set equals stored outside recalibration
    calRaw = sat16(40'(sampleIn.raw)
           + 40'(group10 ? calPend10 : calPend5));
  end

  aic_filter u_filter (
    .filtSel (chCfg[CFG_FILT_LSB +: 3]),
    .bypass  (fastCycle || recalOn),
    .prev    (filtState[ch]),
    .sample  (calRaw),
    .result  (filtered)
  );

  always_comb
  begin
    // Standard or user format, interpolated
    scaled = scale_val(filtered, bipolar, chCfg[CFG_USER_BIT],
                       userLow[ch], userHigh[ch]);
    // Offset added unless recalibrating
    if (recalOn)
      finalValue = scaled;
    else
      finalValue = sat16(40'(scaled) + 40'(alignment_offset_word[ch]));
  end

  // Register decode
  always_comb
  begin
    regCh = regReq.addr[5:3];
    regSlot = regReq.addr[2:0];
    cmdWrite = regReq.wr && regReq.addr == ADDR_CMD;
  end

  // Per-channel state
  always_comb
  begin
    next_cfg = cfg;
    next_userLow = userLow;
    next_userHigh = userHigh;
    next_alignment_offset_word = alignment_offset_word;
    next_filtState = filtState;
    next_chanValue = chanValue;
    if (regReq.wr && !regReq.addr[GLOBAL_BIT])
    begin
      case (regSlot)
        // Filter setting takes effect on the next sample
        SLOT_CFG:   next_cfg[regCh] = regReq.wdata;
        SLOT_LOW:   next_userLow[regCh] = regReq.wdata;
        SLOT_HIGH:  next_userHigh[regCh] = regReq.wdata;
        // Writable in any mode
        SLOT_ALIGN: next_alignment_offset_word[regCh] = regReq.wdata;
        default:    ;
      endcase
    end
    if (accept)
    begin
      next_filtState[ch] = filtered;
      next_chanValue[ch] = finalValue;
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      for (int i = 0; i < NUM_CH; i++)
      begin
        cfg[i] <= CFG_RST;
        userLow[i] <= LOW_RST;
        userHigh[i] <= HIGH_RST;
        alignment_offset_word[i] <= 16'sh0000;
        filtState[i] <= 16'sh0000;
        chanValue[i] <= 16'sh0000;
      end
    end
    else if (clockEn)
    begin
      cfg <= next_cfg;
      userLow <= next_userLow;
      userHigh <= next_userHigh;
      alignment_offset_word <= next_alignment_offset_word;
      filtState <= next_filtState;
      chanValue <= next_chanValue;
    end
  end

  // Mode and calibration coefficients
  always_comb
  begin
    next_fastCycle = fastCycle;
    next_mode = mode;
    next_calStored10 = calStored10;
    next_calStored5 = calStored5;
    next_calPend10 = calPend10;
    next_calPend5 = calPend5;
    next_ch0Raw = ch0Raw;
    if (sampleIn.valid && ch == '0)
      next_ch0Raw = sampleIn.raw;
    if (regReq.wr && regReq.addr == ADDR_CTRL)
      next_fastCycle = regReq.wdata[CTRL_FAST_BIT];
    // Entered regardless of task state
    case (mode)
      MODE_RUN:
      begin
        if (regReq.wr && regReq.addr == ADDR_CTRL
            && regReq.wdata[CTRL_RECAL_BIT])
          next_mode = MODE_RECAL;
      end
      MODE_RECAL:
      begin
        if (regReq.wr && regReq.addr == ADDR_CTRL
            && !regReq.wdata[CTRL_RECAL_BIT])
          next_mode = MODE_EXIT;
        // Reference fixes its own range group
        if (cmdWrite && regReq.wdata[CMD_REF10_BIT])
          next_calPend10 = sat16(40'(RAW_FULL) - 40'(ch0Raw));
        if (cmdWrite && regReq.wdata[CMD_REF5_BIT])
          next_calPend5 = sat16(40'(RAW_FULL) - 40'(ch0Raw));
        if (cmdWrite && regReq.wdata[CMD_SAVE_BIT])
        begin
          next_calStored10 = calPend10;
          next_calStored5 = calPend5;
        end
      end
      MODE_EXIT:
      begin
        // Unsaved coefficients are dropped
        next_calPend10 = calStored10;
        next_calPend5 = calStored5;
        next_mode = MODE_RUN;
      end
      default: next_mode = MODE_RUN;
    endcase
    // Factory values at once, no save
    if (cmdWrite && regReq.wdata[CMD_FACT_BIT])
    begin
      next_calStored10 = CAL_FACTORY;
      next_calStored5 = CAL_FACTORY;
      next_calPend10 = CAL_FACTORY;
      next_calPend5 = CAL_FACTORY;
    end
  end

  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      fastCycle <= 1'b0;
      mode <= MODE_RUN;
      calStored10 <= CAL_FACTORY;
      calStored5 <= CAL_FACTORY;
      calPend10 <= CAL_FACTORY;
      calPend5 <= CAL_FACTORY;
      ch0Raw <= 16'sh0000;
    end
    else if (clockEn)
    begin
      fastCycle <= next_fastCycle;
      mode <= next_mode;
      calStored10 <= next_calStored10;
      calStored5 <= next_calStored5;
      calPend10 <= next_calPend10;
      calPend5 <= next_calPend5;
      ch0Raw <= next_ch0Raw;
    end
  end

  // Result stream and read data
  always_comb
  begin
    next_resultOut.valid = accept;
    next_resultOut.chan = ch;
    // All results flagged while recalibrating
    next_resultOut.invalid = recalOn;
    next_resultOut.value = finalValue;
    next_regRdata = 16'h0000;
    if (regReq.rd)
    begin
      if (regReq.addr[GLOBAL_BIT])
      begin
        case (regReq.addr)
          ADDR_CTRL:  next_regRdata = {14'h0000, recalOn, fastCycle};
          ADDR_CAL10: next_regRdata = calStored10;
          ADDR_CAL5:  next_regRdata = calStored5;
          default:    next_regRdata = 16'h0000;
        endcase
      end
      else
      begin
        case (regSlot)
          SLOT_CFG:    next_regRdata = cfg[regCh];
          SLOT_LOW:    next_regRdata = userLow[regCh];
          SLOT_HIGH:   next_regRdata = userHigh[regCh];
          SLOT_ALIGN:  next_regRdata = alignment_offset_word[regCh];
          SLOT_VALUE:  next_regRdata = chanValue[regCh];
          SLOT_STATUS:
          begin
            next_regRdata[STAT_ALIGN_BIT] =
              (alignment_offset_word[regCh] != 16'sh0000);
            next_regRdata[STAT_INVAL_BIT] = recalOn;
          end
          default:     next_regRdata = 16'h0000;
        endcase
      end
    end
  end

  // Read data stands one cycle only
  always_ff @(posedge clock or negedge rstN)
  begin
    if (!rstN)
    begin
      resultOut <= '0;
      regRdata <= 16'h0000;
    end
    else if (clockEn)
    begin
      resultOut <= next_resultOut;
      regRdata <= next_regRdata;
    end
  end

endmodule

//--- test/aic_checker.sv
/*
  Port-level assertions for the conditioning block.
  Assumes it is bound to aic_top and sees only the top ports.
*/
`timescale 1ns/100ps
module aic_checker
  import aic_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 arst_n,
  input wire logic                 clockEn,
  input wire aic_pkg::aic_regreq_t regReq,
  input wire logic [15:0]          regRdata,
  input wire aic_pkg::aic_sample_t sampleIn,
  input wire aic_pkg::aic_result_t resultOut
);
  logic recal;
  logic next_recal;
  logic leaving;
  logic next_leaving;
  logic take;

  // Track recalibration mode, exit lasts one more cycle
  always_comb
  begin
    next_recal = recal;
    next_leaving = 1'b0;
    if (leaving)
      next_recal = 1'b0;
    else if (regReq.wr && regReq.addr == ADDR_CTRL)
    begin
      if (regReq.wdata[CTRL_RECAL_BIT])
        next_recal = 1'b1;
      else if (recal)
        next_leaving = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      recal <= 1'b0;
      leaving <= 1'b0;
    end
    else if (clockEn)
    begin
      recal <= next_recal;
      leaving <= next_leaving;
    end
  end

  assign take = sampleIn.valid && clockEn;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  a_sample_answer: assert property (
    take && !recal |=> resultOut.valid
      && resultOut.chan == $past(sampleIn.chan))
    else $error("result missing after sample");
  a_no_spurious: assert property (
    !sampleIn.valid && clockEn |=> !resultOut.valid)
    else $error("result without sample");
  a_run_valid: assert property (
    take && !recal |=> !resultOut.invalid)
    else $error("result flagged invalid in run");
  a_recal_invalid: assert property (
    take && recal && sampleIn.chan == 3'h0
      |=> resultOut.valid && resultOut.invalid)
    else $error("channel 0 result wrong in recal");
  a_recal_drop: assert property (
    take && recal && sampleIn.chan != 3'h0 |=> !resultOut.valid)
    else $error("other channel sampled in recal");
  a_status_flag: assert property (
    clockEn && regReq.rd && recal && !regReq.addr[GLOBAL_BIT]
      && regReq.addr[2:0] == SLOT_STATUS |=> regRdata[STAT_INVAL_BIT])
    else $error("invalid flag missing in recal");
  a_rdata_idle: assert property (
    clockEn && !regReq.rd |=> regRdata == 16'h0000)
    else $error("read data outside read answer");
  a_unmapped_zero: assert property (
    clockEn && regReq.rd && regReq.addr > ADDR_CAL5
      |=> regRdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind aic_top aic_checker aic_checker_inst (
  .clock(clock),
  .arst_n(arst_n),
  .clockEn(clockEn),
  .regReq(regReq),
  .regRdata(regRdata),
  .sampleIn(sampleIn),
  .resultOut(resultOut)
);

//--- test/aic_host_model.sv
/*
  Application-side model: keeps the last value handed over per channel.
  Assumes resultOut of aic_top on the same clock.
*/
`timescale 1ns/100ps
module aic_host_model
  import aic_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 arst_n,
  input wire aic_pkg::aic_result_t resultOut,
  input wire logic [2:0]           pickChan,
  output logic [15:0]              heldValue
);
  logic [15:0] seen [NUM_CH];

  // Last value per channel as the program sees it
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      seen <= '{default: 16'h0000};
    else if (resultOut.valid)
      seen[resultOut.chan] <= resultOut.value;
  end

  assign heldValue = seen[pickChan];
endmodule

//--- test/testbench.sv
/*
  Self-checking bench for the conditioning block.
  Assumes aic_top, the bound checker and the host model.
*/
`timescale 1ns/100ps
module testbench;
  import aic_pkg::*;
  logic        clock;
  logic        arst_n;
  logic        clockEn;
  aic_regreq_t regReq;
  logic [15:0] regRdata;
  aic_sample_t sampleIn;
  aic_result_t resultOut;
  logic [2:0]  pickChan;
  logic [15:0] heldValue;
  int          n_errors;
  int          checks_done;
  int          alpha [7] = '{0, 3072, 3584, 3838, 3969, 4030, 4063};

  aic_top aic_top_inst (.clock(clock), .arst_n(arst_n),
    .clockEn(clockEn), .regReq(regReq), .regRdata(regRdata),
    .sampleIn(sampleIn), .resultOut(resultOut));
  aic_host_model aic_host_model_inst (.clock(clock), .arst_n(arst_n),
    .resultOut(resultOut), .pickChan(pickChan), .heldValue(heldValue));

  function automatic logic [15:0] stdv(input int x);
    stdv = 16'((x * 10000 + 8192) >>> 14);
  endfunction

  function automatic logic [15:0] usrv(input int x, lo, hi, bip);
    if (bip)
      usrv = 16'(lo + (((x + 16384) * (hi - lo) + 16384) >>> 15));
    else
      usrv = 16'(lo + ((x * (hi - lo) + 8192) >>> 14));
  endfunction

  task automatic summarize();
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge clock);
    regReq <= '{1'b1, 1'b0, a, d};
    @(posedge clock);
    regReq <= '{1'b0, 1'b0, ~a, ~d};
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge clock);
    regReq <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clock);
    regReq <= '{1'b0, 1'b0, ~a, 16'hFFFF};
    #1 check("regRdata", regRdata, e);
  endtask

  task automatic smp(input logic [2:0] c, input logic signed [15:0] r,
                     input logic v, input logic iv, input logic [15:0] e);
    @(posedge clock);
    sampleIn <= '{1'b1, c, r};
    @(posedge clock);
    sampleIn <= '{1'b0, ~c, ~r};
    #1 check("resultOut.valid", 16'(resultOut.valid), 16'(v));
    if (v)
    begin
      check("resultOut.value", resultOut.value, e);
      check("resultOut.invalid", 16'(resultOut.invalid), 16'(iv));
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  initial
  begin
    repeat (5000) @(posedge clock);
    n_errors++;
    summarize();
  end

  initial
  begin
    arst_n = 1'b0;
    clockEn = 1'b1;
    pickChan = 3'h1;
    regReq = '0;
    sampleIn = '0;
    n_errors = 0;
    checks_done = 0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    repeat (2) @(posedge clock);
    rd(7'h00, CFG_RST);
    rd(7'h0A, HIGH_RST);
    rd(7'h1B, 16'h0000);
    rd(7'h50, 16'h0000);
    smp(3'h0, 16'sh4000, 1'b1, 1'b0, 16'h2710);
    smp(3'h0, -16'sh4000, 1'b1, 1'b0, 16'hD8F0);
    wr(7'h08, 16'h0008);
    smp(3'h1, 16'sh4000, 1'b1, 1'b0, 16'h2710);
    smp(3'h1, 16'sh0000, 1'b1, 1'b0, 16'h0000);
    for (int k = 1; k < 7; k++)
    begin
      wr(7'h10, 16'h0008);
      smp(3'h2, 16'sh0000, 1'b1, 1'b0, 16'h0000);
      wr(7'h10, 16'(8 + k));
      smp(3'h2, 16'sh4000, 1'b1, 1'b0,
          stdv((4096 - alpha[k]) * 4));
    end
    wr(ADDR_CTRL, 16'h0001);
    smp(3'h2, 16'sh4000, 1'b1, 1'b0, 16'h2710);
    wr(ADDR_CTRL, 16'h0000);
    wr(7'h10, 16'h0008);
    wr(7'h18, 16'h0068);
    wr(7'h19, 16'h0C80);
    wr(7'h1A, 16'h2580);
    smp(3'h3, 16'sh4000, 1'b1, 1'b0, usrv(16384, 3200, 9600, 0));
    smp(3'h3, 16'sh0002, 1'b1, 1'b0, usrv(2, 3200, 9600, 0));
    wr(7'h20, 16'h0040);
    wr(7'h21, 16'h8AD0);
    wr(7'h22, 16'h7530);
    smp(3'h4, -16'sh4000, 1'b1, 1'b0,
        usrv(-16384, -30000, 30000, 1));
    smp(3'h4, 16'sh4000, 1'b1, 1'b0,
        usrv(16384, -30000, 30000, 1));
    wr(7'h0B, 16'h000A);
    rd(7'h0D, 16'h0001);
    smp(3'h1, 16'sh4000, 1'b1, 1'b0, 16'h271A);
    wr(7'h0B, 16'hFC18);
    smp(3'h1, 16'sh0000, 1'b1, 1'b0, 16'hFC18);
    rd(7'h0B, 16'hFC18);
    @(posedge clock);
    clockEn <= 1'b0;
    smp(3'h1, 16'sh1000, 1'b0, 1'b0, 16'h0000);
    @(posedge clock);
    clockEn <= 1'b1;
    rd(7'h0C, 16'hFC18);
    wr(7'h03, 16'h0005);
    wr(ADDR_CTRL, 16'h0002);
    rd(ADDR_CTRL, 16'h0002);
    rd(7'h15, 16'h0004);
    smp(3'h1, 16'sh1388, 1'b0, 1'b0, 16'h0000);
    rd(7'h0C, 16'hFC18);
    check("heldValue", heldValue, 16'hFC18);
    smp(3'h0, 16'sh3E80, 1'b1, 1'b1, stdv(16000));
    wr(ADDR_CMD, 16'h0001);
    smp(3'h0, 16'sh3E80, 1'b1, 1'b1, 16'h2710);
    wr(ADDR_CTRL, 16'h0000);
    smp(3'h0, 16'sh3E80, 1'b1, 1'b0, stdv(16000) + 16'h0005);
    wr(ADDR_CTRL, 16'h0002);
    smp(3'h0, 16'sh3E80, 1'b1, 1'b1, stdv(16000));
    wr(ADDR_CMD, 16'h0003);
    wr(ADDR_CMD, 16'h0004);
    wr(ADDR_CTRL, 16'h0000);
    rd(ADDR_CAL10, 16'h0180);
    rd(ADDR_CAL5, 16'h0180);
    smp(3'h2, 16'sh3E80, 1'b1, 1'b0, 16'h2710);
    smp(3'h3, 16'sh2000, 1'b1, 1'b0, usrv(8576, 3200, 9600, 0));
    wr(ADDR_CMD, 16'h0008);
    rd(ADDR_CAL10, 16'h0000);
    smp(3'h0, 16'sh3E80, 1'b1, 1'b0, stdv(16000) + 16'h0005);
    summarize();
  end
endmodule
